// ==== core/psic_ctrl.sv ====
// Purpose: Status summary word and interrupt control behind APB
// Assumes: PHY status inputs are on CORE_CLK; the pin input is not
// Notes:   Answers with pready high in every access phase
`timescale 1ns/10ps
module psic_ctrl (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [9:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        LINK_UP,
    input  wire logic        SPEED_IS_LOW,
    input  wire logic        FULL_DUPLEX,
    input  wire logic        LOOPBACK_ON,
    input  wire logic        AN_COMPLETE,
    input  wire logic        JABBER,
    input  wire logic        ENERGY_DETECT,
    input  wire logic        FC_HALF_FULL,
    input  wire logic        RX_ERR_HALF_FULL,
    input  wire logic        PD_IRQ_PIN_I,
    output logic             PD_IRQ_PIN_O,
    output logic             PD_IRQ_PIN_OE,
    output logic             POWER_DOWN,
    output logic             IRQ
);

    localparam int NE = psic_pkg::EVT_NUM;
    localparam int FL = psic_pkg::EVT_FLAG_LSB;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                    prdata;
        logic [psic_pkg::CTL_WIDTH-1:0] ctl;
        logic [NE-1:0]                  en;
        logic                           pd_s1;
        logic                           pd_s2;
    } psic_ctrl_s;

    psic_ctrl_s s_q;
    psic_ctrl_s s_d;

    logic [NE-1:0] ev_lvl;
    logic [NE-1:0] ev_flag;
    logic [NE-1:0] ev_clr;
    logic [15:0]   stat_w;
    logic          setup;
    logic          access;
    logic          hit_sts;
    logic          hit_ctl;
    logic          hit_evt;
    logic          irq_w;

    // ------------------------------------------------------------------
    // Event latches
    // ------------------------------------------------------------------
    always_comb begin
        ev_lvl = '0;
        ev_lvl[psic_pkg::EVT_RX_ERR_HALF] = RX_ERR_HALF_FULL;
        ev_lvl[psic_pkg::EVT_FC_HALF]     = FC_HALF_FULL;
        ev_lvl[psic_pkg::EVT_AN_DONE]     = AN_COMPLETE;
        ev_lvl[psic_pkg::EVT_DUPLEX]      = FULL_DUPLEX;
        ev_lvl[psic_pkg::EVT_SPEED]       = SPEED_IS_LOW;
        ev_lvl[psic_pkg::EVT_LINK]        = LINK_UP;
        ev_lvl[psic_pkg::EVT_ENERGY]      = ENERGY_DETECT;
    end

    psic_evt_if ev [NE] ();

    genvar gi;
    generate
        for (gi = 0; gi < NE; gi++) begin : g_evt
            assign ev[gi].level = ev_lvl[gi];
            assign ev[gi].clr   = ev_clr[gi];
            assign ev_flag[gi]  = ev[gi].flag;
            psic_event #(
                .ANY_EDGE (psic_pkg::EVT_ANY_EDGE[gi])
            ) u_evt (
                .clk   (CORE_CLK),
                .rst_n (RESET_N),
                .evt   (ev[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status summary word, live and never cleared by reads
    // ------------------------------------------------------------------
    always_comb begin
        stat_w = '0;
        stat_w[psic_pkg::STS_JABBER]   = JABBER & SPEED_IS_LOW;
        stat_w[psic_pkg::STS_AN_DONE]  = AN_COMPLETE;
        stat_w[psic_pkg::STS_LOOPBACK] = LOOPBACK_ON;
        stat_w[psic_pkg::STS_DUPLEX]   = FULL_DUPLEX;
        stat_w[psic_pkg::STS_SPEED]    = SPEED_IS_LOW;
        stat_w[psic_pkg::STS_LINK]     = LINK_UP;
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign setup   = PSEL & ~PENABLE;
    assign access  = PSEL & PENABLE;
    assign hit_sts = (PADDR == psic_pkg::PHY_STATUS_SUMMARY_ADR);
    assign hit_ctl = (PADDR == psic_pkg::IRQ_CONTROL_ADR);
    assign hit_evt = (PADDR == psic_pkg::EVENT_STATUS_EN_ADR);
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~(hit_sts | hit_ctl | hit_evt);
    assign PRDATA  = s_q.prdata;

    // Clear only the flags already shown to software
    assign ev_clr = (access & ~PWRITE & hit_evt)
                    ? s_q.prdata[FL +: NE] : '0;

    always_comb begin
        s_d = s_q;
        s_d.pd_s1 = PD_IRQ_PIN_I;
        s_d.pd_s2 = s_q.pd_s1;
        if (setup && !PWRITE) begin
            s_d.prdata = psic_pkg::PRDATA_RST;
            if (hit_sts) begin
                s_d.prdata[15:0] = stat_w;
            end else if (hit_ctl) begin
                s_d.prdata[psic_pkg::CTL_WIDTH-1:0] = s_q.ctl;
            end else if (hit_evt) begin
                s_d.prdata[FL +: NE] = ev_flag;
                s_d.prdata[NE-1:0]   = s_q.en;
            end
        end
        if (access && PWRITE && hit_ctl) begin
            s_d.ctl = PWDATA[psic_pkg::CTL_WIDTH-1:0];
        end
        if (access && PWRITE && hit_evt) begin
            s_d.en = PWDATA[NE-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q.prdata <= psic_pkg::PRDATA_RST;
            s_q.ctl    <= psic_pkg::IRQ_CONTROL_RST;
            s_q.en     <= psic_pkg::EVENT_EN_RST;
            s_q.pd_s1  <= 1'b0;
            s_q.pd_s2  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and shared pin
    // ------------------------------------------------------------------
    assign irq_w = s_q.ctl[psic_pkg::CTL_TEST]
                 | (s_q.ctl[psic_pkg::CTL_GLOBAL]
                    & (|(ev_flag & s_q.en)));
    assign IRQ           = irq_w;
    assign PD_IRQ_PIN_OE = s_q.ctl[psic_pkg::CTL_PIN_OE];
    assign PD_IRQ_PIN_O  = irq_w & s_q.ctl[psic_pkg::CTL_PIN_OE];
    assign POWER_DOWN    = s_q.pd_s2 & ~s_q.ctl[psic_pkg::CTL_PIN_OE];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    jabber_gate_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_sts) |=>
            PRDATA[5] == ($past(JABBER) && $past(SPEED_IS_LOW)))
        else $error("jabber bit not gated by speed");

    jabber_keep_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (access && !PWRITE && hit_sts && $stable(JABBER)
            && $stable(SPEED_IS_LOW)) |-> $stable(stat_w[5]))
        else $error("jabber bit changed by read");

    an_done_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_sts) |=> PRDATA[4] == $past(AN_COMPLETE))
        else $error("negotiation bit wrong");

    loop_bit_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_sts) |=> PRDATA[3] == $past(LOOPBACK_ON))
        else $error("loopback bit wrong");

    duplex_bit_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_sts) |=> PRDATA[2] == $past(FULL_DUPLEX))
        else $error("duplex bit wrong");

    speed_bit_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_sts) |=> PRDATA[1] == $past(SPEED_IS_LOW))
        else $error("speed bit wrong");

    link_bit_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_sts) |=> PRDATA[0] == $past(LINK_UP))
        else $error("link bit wrong");

    link_keep_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (access && !PWRITE && hit_sts) |=>
            (!$stable(LINK_UP) || $stable(stat_w[0])))
        else $error("link bit changed by read");

    ctl_reserved_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_ctl) |=> PRDATA[31:3] == 29'h0)
        else $error("reserved control bits not zero");

    test_irq_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (access && PWRITE && hit_ctl && PWDATA[2]) |=> IRQ)
        else $error("test interrupt not raised");

    global_gate_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (!s_q.ctl[2] && !s_q.ctl[1]) |-> !IRQ)
        else $error("interrupt without enable");

    pin_role_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (access && PWRITE && hit_ctl) |=>
            (PD_IRQ_PIN_OE == $past(PWDATA[0]))
                && (!PD_IRQ_PIN_OE
                    || (PD_IRQ_PIN_O == IRQ && !POWER_DOWN)))
        else $error("pin role wrong");

    pd_input_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        ($past(RESET_N, 2) && !PD_IRQ_PIN_OE)
            |-> POWER_DOWN == $past(PD_IRQ_PIN_I, 2))
        else $error("power-down input not followed");

    flag_latch_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(AN_COMPLETE) |=> ev_flag[2])
        else $error("event flag not latched");

    flag_clear_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (access && !PWRITE && hit_evt && $stable(ev_lvl)) |=>
            (ev_flag & $past(PRDATA[FL +: NE])) == '0)
        else $error("shown event flag not cleared");

    irq_event_a: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (s_q.ctl[1] && s_q.en[5] && $changed(LINK_UP)
            && !(access && PWRITE && (hit_ctl || hit_evt))) |=> IRQ)
        else $error("enabled event gave no interrupt");

endmodule : psic_ctrl

// ==== core/psic_pkg.sv ====
// Purpose: Shared constants for the status summary and interrupt block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Byte address is four times the register index
package psic_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] PHY_STATUS_SUMMARY_IDX = 8'h10;
    localparam logic [7:0] IRQ_CONTROL_IDX        = 8'h11;
    localparam logic [7:0] EVENT_STATUS_EN_IDX    = 8'h12;
    localparam logic [9:0] PHY_STATUS_SUMMARY_ADR =
        {PHY_STATUS_SUMMARY_IDX, 2'h0};
    localparam logic [9:0] IRQ_CONTROL_ADR        =
        {IRQ_CONTROL_IDX, 2'h0};
    localparam logic [9:0] EVENT_STATUS_EN_ADR    =
        {EVENT_STATUS_EN_IDX, 2'h0};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int STS_LINK     = 0;
    localparam int STS_SPEED    = 1;
    localparam int STS_DUPLEX   = 2;
    localparam int STS_LOOPBACK = 3;
    localparam int STS_AN_DONE  = 4;
    localparam int STS_JABBER   = 5;
    localparam int CTL_PIN_OE   = 0;
    localparam int CTL_GLOBAL   = 1;
    localparam int CTL_TEST     = 2;
    localparam int CTL_WIDTH    = 3;
    localparam int EVT_NUM      = 7;
    localparam int EVT_FLAG_LSB = 8;

    // Event order inside the flag and enable fields
    localparam int EVT_RX_ERR_HALF = 0;
    localparam int EVT_FC_HALF     = 1;
    localparam int EVT_AN_DONE     = 2;
    localparam int EVT_DUPLEX      = 3;
    localparam int EVT_SPEED       = 4;
    localparam int EVT_LINK        = 5;
    localparam int EVT_ENERGY      = 6;

    // Events that fire on any change rather than on rising only
    localparam logic [EVT_NUM-1:0] EVT_ANY_EDGE = 7'h78;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CTL_WIDTH-1:0] IRQ_CONTROL_RST = 3'h0;
    localparam logic [EVT_NUM-1:0]   EVENT_EN_RST    = 7'h00;
    localparam logic [31:0]          PRDATA_RST      = 32'h00000000;

endpackage : psic_pkg

// ==== core/psic_evt_if.sv ====
// Purpose: Carries one event between the controller and its latch
// Assumes: All signals on the controller clock
// Notes:   level and clr driven by controller, flag by latch
`timescale 1ns/10ps
interface psic_evt_if;
    logic level;
    logic clr;
    logic flag;

    modport ctrl  (output level, output clr, input flag);
    modport latch (input level, input clr, output flag);
endinterface : psic_evt_if

// ==== core/psic_event.sv ====
// Purpose: Sticky event flag with edge detection
// Assumes: Level input is on the same clock
// Notes:   A new event in the clear cycle keeps the flag set
`timescale 1ns/10ps
module psic_event #(
    parameter bit ANY_EDGE = 1'b1
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    psic_evt_if.latch   evt
);

    typedef struct packed {
        logic prev;
        logic flag;
    } psic_evt_s;

    psic_evt_s s_q;
    psic_evt_s s_d;
    logic      hit;

    always_comb begin
        hit = ANY_EDGE ? (evt.level ^ s_q.prev) : (evt.level & ~s_q.prev);
        s_d = s_q;
        s_d.prev = evt.level;
        // Set beats clear
        s_d.flag = hit | (s_q.flag & ~evt.clr);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evt.flag = s_q.flag;

endmodule : psic_event

// ==== testbench/phy_status_irq_control_test.sv ====
// Purpose: Self-checking bench for the status summary and interrupt block
// Assumes: APB slave answers in the access phase; one clock domain
// Notes:   PHY levels drawn from an LFSR seeded at 32'h6851
`timescale 1ns/10ps
module phy_status_irq_control_test;
    logic        core_clk        = 1'b0;
    logic        reset_n         = 1'b0;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [9:0]  paddr           = 10'h000;
    logic [31:0] pwdata          = 32'h0;
    logic [6:0]  evt_in          = 7'h00;  // Levels in event order
    logic        loop_on         = 1'b0;
    logic        jabber          = 1'b0;
    logic        pin_drv         = 1'b0;
    logic [31:0] lfsr            = 32'h6851;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] ex;
    logic        pready;
    logic        pslverr;
    logic        pin_o;
    logic        pin_oe;
    logic        pin_w;
    logic        pwr_dn;
    logic        irq;
    logic        er;
    int          n_fail          = 0;
    int          samples_checked = 0;

    // ------------------------------------------------------------------
    // Clock, shared pin and design
    // ------------------------------------------------------------------
    always #25 core_clk = ~core_clk;
    assign pin_w = pin_oe ? pin_o : pin_drv;

    psic_ctrl u_psic_ctrl (
        .CORE_CLK(core_clk),          .RESET_N(reset_n),
        .PSEL(psel),                  .PENABLE(penable),
        .PWRITE(pwrite),              .PADDR(paddr),
        .PWDATA(pwdata),              .PRDATA(prdata),
        .PREADY(pready),              .PSLVERR(pslverr),
        .LINK_UP(evt_in[5]),          .SPEED_IS_LOW(evt_in[4]),
        .FULL_DUPLEX(evt_in[3]),      .LOOPBACK_ON(loop_on),
        .AN_COMPLETE(evt_in[2]),      .JABBER(jabber),
        .ENERGY_DETECT(evt_in[6]),    .FC_HALF_FULL(evt_in[1]),
        .RX_ERR_HALF_FULL(evt_in[0]), .PD_IRQ_PIN_I(pin_w),
        .PD_IRQ_PIN_O(pin_o),         .PD_IRQ_PIN_OE(pin_oe),
        .POWER_DOWN(pwr_dn),          .IRQ(irq)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [31:0] exp_sts(input logic [6:0] e,
                                            input logic lp,
                                            input logic jb);
        return {26'h0, jb & e[4], e[2], lp, e[3], e[4], e[5]};
    endfunction : exp_sts

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [9:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_fail++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : apb

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        apb(1'b0, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
        chk("control reset", rd, 32'h0);
        apb(1'b0, psic_pkg::EVENT_STATUS_EN_ADR, 32'h0);
        chk("events reset", rd, 32'h0);
        $display("reset test done");

        for (int i = 0; i < 40; i++) begin
            lfsr = lfsr_next(lfsr);
            evt_in  <= {3'h0, lfsr[3:0]} << 2;
            loop_on <= lfsr[4];
            jabber  <= (i == 0) ? 1'b1 : lfsr[5];
            ex = exp_sts({1'b0, lfsr[3:0], 2'b0}, lfsr[4],
                         (i == 0) | lfsr[5]);
            apb(1'b0, psic_pkg::PHY_STATUS_SUMMARY_ADR, 32'h0);
            chk("summary", rd, ex);
            apb(1'b0, psic_pkg::PHY_STATUS_SUMMARY_ADR, 32'h0);
            chk("summary reread", rd, ex);
            if (lfsr[3] && lfsr[0]) begin
                chk("trusted mode", rd & 32'h6, ex & 32'h6);
            end
        end
        evt_in  <= 7'h00;
        loop_on <= 1'b0;
        jabber  <= 1'b0;
        apb(1'b0, psic_pkg::EVENT_STATUS_EN_ADR, 32'h0);
        $display("summary test done");

        apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'hfffffff8);
        apb(1'b0, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
        chk("reserved control", rd, 32'h0);
        pin_drv <= 1'b1;
        apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h4);
        chk("test irq", {31'h0, irq}, 32'h1);
        chk("pin input", {30'h0, pin_oe, pwr_dn}, 32'h1);
        apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h5);
        apb(1'b0, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
        chk("control rw", rd, 32'h5);
        chk("pin output", {29'h0, pin_oe, pin_o, pwr_dn}, 32'h6);
        apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
        chk("test irq off", {31'h0, irq}, 32'h0);
        $display("control test done");

        apb(1'b1, psic_pkg::EVENT_STATUS_EN_ADR, 32'h7f);
        for (int i = 0; i < 7; i++) begin
            evt_in <= 7'h01 << i;
            repeat (3) @(posedge core_clk);
            chk("gated irq", {31'h0, irq}, 32'h0);
            apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h2);
            chk("event irq", {31'h0, irq}, 32'h1);
            apb(1'b1, psic_pkg::EVENT_STATUS_EN_ADR,
                32'h7f & ~(32'h1 << i));
            chk("masked irq", {31'h0, irq}, 32'h0);
            apb(1'b1, psic_pkg::EVENT_STATUS_EN_ADR, 32'h7f);
            apb(1'b0, psic_pkg::EVENT_STATUS_EN_ADR, 32'h0);
            chk("event flag", rd, (32'h100 << i) | 32'h7f);
            chk("cleared irq", {31'h0, irq}, 32'h0);
            apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
            evt_in <= 7'h00;
            repeat (3) @(posedge core_clk);
            ex = psic_pkg::EVT_ANY_EDGE[i] ? (32'h100 << i) : 32'h0;
            apb(1'b0, psic_pkg::EVENT_STATUS_EN_ADR, 32'h0);
            chk("fall flag", rd, ex | 32'h7f);
        end
        apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h2);
        evt_in <= 7'h20;
        repeat (3) @(posedge core_clk);
        chk("live event irq", {31'h0, irq}, 32'h1);
        apb(1'b0, psic_pkg::EVENT_STATUS_EN_ADR, 32'h0);
        chk("live flag", rd, 32'h207f);
        chk("live cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
        evt_in <= 7'h00;
        $display("event test done");

        apb(1'b0, 10'h04c, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        apb(1'b0, psic_pkg::IRQ_CONTROL_ADR, 32'h0);
        chk("mapped ok", {31'h0, er}, 32'h0);
        $display("bus test done");
        wrap_up();
    end

    initial begin
        #(50 * 100000);
        n_fail++;
        wrap_up();
    end
endmodule : phy_status_irq_control_test
